// *** src/uip_pkg.sv ***
// Purpose: shared constants and carrier types of the uart interrupt prioritizer
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   source index order is also the priority order, index 0 highest
package uip_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam int unsigned ADDR_W = 5;
    localparam logic [4:0] OFF_ENABLE = 5'h00;
    localparam logic [4:0] OFF_IDENT = 5'h04;
    localparam logic [4:0] OFF_LSTAT = 5'h08;
    localparam logic [4:0] OFF_RXHOLD = 5'h0c;
    localparam logic [4:0] OFF_TXHOLD = 5'h10;
    localparam logic [4:0] OFF_EVT_STAT = 5'h14;
    localparam logic [4:0] OFF_EVT_MASK = 5'h18;

    // ----------------------------------------
    // enable register fields
    // ----------------------------------------
    localparam int unsigned EN_RX = 0;
    localparam int unsigned EN_TX = 1;
    localparam int unsigned EN_LS = 2;
    localparam int unsigned EN_MODEM = 3;
    localparam int unsigned EN_XOFF = 5;
    localparam int unsigned EN_RTS = 6;
    localparam int unsigned EN_CTS = 7;

    // ----------------------------------------
    // line status fields
    // ----------------------------------------
    localparam int unsigned LS_ERR_BIT = 7;
    localparam int unsigned LS_OVR_BIT = 1;

    // ----------------------------------------
    // sources, in priority order
    // ----------------------------------------
    localparam int unsigned NUM_SRC = 7;
    localparam int unsigned NUM_TYPES = 6;
    localparam int unsigned SRC_LS = 0;
    localparam int unsigned SRC_TMO = 1;
    localparam int unsigned SRC_RX = 2;
    localparam int unsigned SRC_TX = 3;
    localparam int unsigned SRC_MODEM = 4;
    localparam int unsigned SRC_XOFF = 5;
    localparam int unsigned SRC_FLOW = 6;

    // ----------------------------------------
    // identification codes, bit 0 set means nothing pending
    // ----------------------------------------
    localparam logic [5:0] CODE_NONE = 6'h01;
    localparam logic [5:0] CODE_LS = 6'h06;
    localparam logic [5:0] CODE_TMO = 6'h0c;
    localparam logic [5:0] CODE_RX = 6'h04;
    localparam logic [5:0] CODE_TX = 6'h02;
    localparam logic [5:0] CODE_MODEM = 6'h00;
    localparam logic [5:0] CODE_XOFF = 6'h10;
    localparam logic [5:0] CODE_FLOW = 6'h20;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [7:0] IDENT_RST = 8'h01;
    localparam logic [5:0] EVT_MASK_RST = 6'h00;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic err_in_fifo;
        logic overrun_evt;
        logic rx_timeout_evt;
        logic rx_data_ready;
        logic rx_above_trig;
        logic fifo_enable;
        logic tx_holding_empty;
        logic tx_above_trig;
        logic modem_delta;
        logic xoff_evt;
        logic xon_evt;
        logic flow_evt;
        logic [7:0] line_status_in;
    } uip_src_t;

    typedef struct packed {
        logic rx_read;
        logic tx_write;
        logic [7:0] tx_data;
        logic lsr_read;
    } uip_strobe_t;
endpackage : uip_pkg

// *** src/uip_prio.sv ***
// Purpose: fixed priority encoder from pending sources to identification code
// Assumes: pend bit 0 is the highest priority
// Notes:   purely combinational; the caller registers the result
`timescale 1ns/1ps
module uip_prio (
    input wire logic [uip_pkg::NUM_SRC-1:0] pend, // enabled pending sources
    output logic [5:0] code // code of the highest pending source
);
    function automatic logic [5:0] code_of(input int unsigned idx);
        case (idx)
            uip_pkg::SRC_LS: code_of = uip_pkg::CODE_LS;
            uip_pkg::SRC_TMO: code_of = uip_pkg::CODE_TMO;
            uip_pkg::SRC_RX: code_of = uip_pkg::CODE_RX;
            uip_pkg::SRC_TX: code_of = uip_pkg::CODE_TX;
            uip_pkg::SRC_MODEM: code_of = uip_pkg::CODE_MODEM;
            uip_pkg::SRC_XOFF: code_of = uip_pkg::CODE_XOFF;
            uip_pkg::SRC_FLOW: code_of = uip_pkg::CODE_FLOW;
            default: code_of = uip_pkg::CODE_NONE;
        endcase
    endfunction : code_of

    // lowest priority first so the highest pending source overwrites last
    always_comb begin
        code = uip_pkg::CODE_NONE;
        for (int i = uip_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                code = code_of(i);
            end
        end
    end
endmodule : uip_prio

// *** src/uip_top.sv ***
// Purpose: interrupt generation and prioritization for one uart channel
// Assumes: source signals come from uart logic on core_clk, no synchronisers
// Notes:   apb slave, fixed one-cycle access phase
//
// What this block does
// - six types ranked, highest pending reported
// - each type has its own enable bit
// - all enable bits cleared silences uart_int; evt_irq keeps following sticky status
// - ident flags pending and gives type code
// - line status from errors in receive fifo
// - overrun cause cleared by line status read
// - receive time-out cleared by holding read
// - receive data from ready or trigger level
// - transmit empty cleared by ident read or holding write
// - ident resets to bit 0 set only
// - error summary follows errored characters in fifo
// - low enable bits select interrupt mode
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module uip_top (
    input wire logic core_clk, // 100 MHz clock
    input wire logic rst_n, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [uip_pkg::ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire uip_pkg::uip_src_t src, // uart core conditions and events
    output uip_pkg::uip_strobe_t strobe, // access pulses to the uart core
    output logic uart_int, // host interrupt, active high
    output logic irq_mode, // interrupt mode rather than polled
    output logic evt_irq // sticky event interrupt, active high
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [7:0] enable_reg;
    logic [7:0] ident_reg;
    logic uart_int_reg;
    logic irq_mode_reg;
    logic evt_irq_reg;
    logic [uip_pkg::NUM_TYPES-1:0] evt_stat_reg;
    logic [uip_pkg::NUM_TYPES-1:0] evt_mask_reg;
    logic [uip_pkg::NUM_TYPES-1:0] type_prev_reg;
    uip_pkg::uip_strobe_t strobe_reg;
    logic ovr_reg;
    logic ls_err_reg;
    logic tmo_reg;
    logic thr_reg;
    logic thr_prev_reg;
    logic xoff_reg;
    logic flow_reg;
    logic [uip_pkg::NUM_SRC-1:0] raw;
    logic [uip_pkg::NUM_SRC-1:0] src_en;
    logic [uip_pkg::NUM_SRC-1:0] pend;
    logic [uip_pkg::NUM_TYPES-1:0] type_pend;
    logic [5:0] code;
    logic setup;
    logic access;
    logic wr_en;
    logic rd_en;
    logic rx_cond;
    logic thr_cond;
    logic thr_rise;
    logic ident_rd;
    logic lsr_rd;
    logic rhr_rd;
    logic thr_wr;
    logic [7:0] lstat_view;

    function automatic logic addr_ok(input logic [uip_pkg::ADDR_W-1:0] a);
        case (a)
            uip_pkg::OFF_ENABLE, uip_pkg::OFF_IDENT, uip_pkg::OFF_LSTAT,
            uip_pkg::OFF_RXHOLD, uip_pkg::OFF_TXHOLD, uip_pkg::OFF_EVT_STAT,
            uip_pkg::OFF_EVT_MASK: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    endfunction : addr_ok

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    assign setup = psel & ~penable;
    assign access = psel & penable & pready_reg;
    assign wr_en = access & pwrite & addr_ok(paddr);
    assign rd_en = access & ~pwrite & addr_ok(paddr);
    assign ident_rd = rd_en & (paddr == uip_pkg::OFF_IDENT);
    assign lsr_rd = rd_en & (paddr == uip_pkg::OFF_LSTAT);
    assign rhr_rd = rd_en & (paddr == uip_pkg::OFF_RXHOLD);
    assign thr_wr = wr_en & (paddr == uip_pkg::OFF_TXHOLD);

    always_comb begin
        lstat_view = src.line_status_in;
        lstat_view[uip_pkg::LS_ERR_BIT] = ls_err_reg;
        lstat_view[uip_pkg::LS_OVR_BIT] = ovr_reg;
    end

    // read data is captured in the setup cycle and held through the access
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= setup;
            if (setup) begin
                pslverr_reg <= ~addr_ok(paddr);
                case (paddr)
                    uip_pkg::OFF_ENABLE: prdata_reg <= {24'h000000, enable_reg};
                    uip_pkg::OFF_IDENT: prdata_reg <= {24'h000000, ident_reg};
                    uip_pkg::OFF_LSTAT: prdata_reg <= {24'h000000, lstat_view};
                    uip_pkg::OFF_EVT_STAT: prdata_reg <= {26'h0000000, evt_stat_reg};
                    uip_pkg::OFF_EVT_MASK: prdata_reg <= {26'h0000000, evt_mask_reg};
                    default: prdata_reg <= 32'h0000_0000;
                endcase
            end else if (access) begin
                pslverr_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_reg <= uip_pkg::ENABLE_RST;
        end else if (wr_en && paddr == uip_pkg::OFF_ENABLE) begin
            enable_reg <= pwdata[7:0];
        end
    end

    // holding register data is owned by the uart core; we only pulse it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_reg <= '0;
        end else begin
            strobe_reg.rx_read <= rhr_rd;
            strobe_reg.tx_write <= thr_wr;
            strobe_reg.lsr_read <= lsr_rd;
            if (thr_wr) begin
                strobe_reg.tx_data <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------
    // source conditions
    // ----------------------------------------
    assign rx_cond = src.fifo_enable ? src.rx_above_trig : src.rx_data_ready;
    assign thr_cond = src.fifo_enable ? src.tx_above_trig : src.tx_holding_empty;
    assign thr_rise = thr_cond & ~thr_prev_reg;

    // overrun cleared by status read, a new event wins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ovr_reg <= 1'b0;
            ls_err_reg <= 1'b0;
        end else begin
            ovr_reg <= src.overrun_evt | (ovr_reg & ~lsr_rd);
            ls_err_reg <= src.err_in_fifo;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tmo_reg <= 1'b0;
        end else begin
            tmo_reg <= src.rx_timeout_evt | (tmo_reg & ~rhr_rd);
        end
    end

    // transmit empty edge, cleared by write or ident read of it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            thr_reg <= 1'b0;
            thr_prev_reg <= 1'b0;
        end else begin
            thr_prev_reg <= thr_cond;
            thr_reg <= thr_rise | (thr_reg & ~(thr_wr |
                       (ident_rd && prdata_reg[5:0] == uip_pkg::CODE_TX)));
        end
    end

    // flow sources stay sticky until their clearing action
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            xoff_reg <= 1'b0;
            flow_reg <= 1'b0;
        end else begin
            xoff_reg <= src.xoff_evt | (xoff_reg & ~(src.xon_evt | ident_rd));
            flow_reg <= src.flow_evt | (flow_reg & ~ident_rd);
        end
    end

    // ----------------------------------------
    // gating and priority
    // ----------------------------------------
    // raw source conditions, bit index in priority order
    assign raw = {flow_reg, xoff_reg, src.modem_delta, thr_reg, rx_cond, tmo_reg,
                  ovr_reg | ls_err_reg};
    // per-type enables, all zero masks every source
    assign src_en = {enable_reg[uip_pkg::EN_RTS] | enable_reg[uip_pkg::EN_CTS],
                     enable_reg[uip_pkg::EN_XOFF], enable_reg[uip_pkg::EN_MODEM],
                     enable_reg[uip_pkg::EN_TX], enable_reg[uip_pkg::EN_RX],
                     enable_reg[uip_pkg::EN_RX], enable_reg[uip_pkg::EN_LS]};
    assign pend = raw & src_en;

    uip_prio u_prio (
        .pend(pend),
        .code(code)
    );

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ident_reg <= uip_pkg::IDENT_RST;
        end else begin
            ident_reg <= {2'b00, code};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            uart_int_reg <= 1'b0;
            irq_mode_reg <= 1'b0;
        end else begin
            uart_int_reg <= |pend;
            irq_mode_reg <= |enable_reg[3:0];
        end
    end

    // ----------------------------------------
    // sticky event status, write one to clear, set wins
    // ----------------------------------------
    assign type_pend = {pend[uip_pkg::SRC_FLOW], pend[uip_pkg::SRC_XOFF],
                        pend[uip_pkg::SRC_MODEM], pend[uip_pkg::SRC_TX],
                        pend[uip_pkg::SRC_TMO] | pend[uip_pkg::SRC_RX],
                        pend[uip_pkg::SRC_LS]};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_stat_reg <= '0;
            evt_mask_reg <= uip_pkg::EVT_MASK_RST;
            type_prev_reg <= '0;
            evt_irq_reg <= 1'b0;
        end else begin
            type_prev_reg <= type_pend;
            if (wr_en && paddr == uip_pkg::OFF_EVT_STAT) begin
                evt_stat_reg <= (evt_stat_reg & ~pwdata[5:0]) | (type_pend & ~type_prev_reg);
            end else begin
                evt_stat_reg <= evt_stat_reg | (type_pend & ~type_prev_reg);
            end
            if (wr_en && paddr == uip_pkg::OFF_EVT_MASK) begin
                evt_mask_reg <= pwdata[5:0];
            end
            evt_irq_reg <= |(evt_stat_reg & evt_mask_reg);
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign strobe = strobe_reg;
    assign uart_int = uart_int_reg;
    assign irq_mode = irq_mode_reg;
    assign evt_irq = evt_irq_reg;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_pri_ls;
        pend[uip_pkg::SRC_LS] |=> ident_reg[5:0] == uip_pkg::CODE_LS;
    endproperty
    a_pri_ls: assert property (p_pri_ls) else $error("line status not top priority");

    property p_rx_code;
        pend[uip_pkg::SRC_RX] && !pend[uip_pkg::SRC_LS] && !pend[uip_pkg::SRC_TMO]
            |=> ident_reg[5:0] == uip_pkg::CODE_RX;
    endproperty
    a_rx_code: assert property (p_rx_code) else $error("receive data code wrong");

    property p_none;
        pend == '0 |=> ident_reg == uip_pkg::IDENT_RST && !uart_int_reg;
    endproperty
    a_none: assert property (p_none) else $error("ident not idle with nothing pending");

    property p_all_off;
        enable_reg == 8'h00 |=> !uart_int_reg;
    endproperty
    a_all_off: assert property (p_all_off) else $error("interrupt with all enables off");

    property p_gate;
        raw[uip_pkg::SRC_TX] && !enable_reg[uip_pkg::EN_TX] |-> !pend[uip_pkg::SRC_TX];
    endproperty
    a_gate: assert property (p_gate) else $error("disabled source pending");

    property p_ovr_clr;
        lsr_rd && !src.overrun_evt |=> !ovr_reg;
    endproperty
    a_ovr_clr: assert property (p_ovr_clr) else $error("overrun not cleared by read");

    property p_tmo_clr;
        rhr_rd && !src.rx_timeout_evt |=> !tmo_reg;
    endproperty
    a_tmo_clr: assert property (p_tmo_clr) else $error("time-out not cleared by read");

    property p_thr_clr;
        thr_wr && !thr_rise |=> !thr_reg;
    endproperty
    a_thr_clr: assert property (p_thr_clr) else $error("transmit empty not cleared");

    property p_err_int;
        (src.err_in_fifo && enable_reg[uip_pkg::EN_LS]) ##1 enable_reg[uip_pkg::EN_LS]
            |=> uart_int_reg && ident_reg[5:0] == uip_pkg::CODE_LS;
    endproperty
    a_err_int: assert property (p_err_int) else $error("error summary gave no interrupt");

    property p_mode;
        (|enable_reg[3:0]) |=> irq_mode_reg;
    endproperty
    a_mode: assert property (p_mode) else $error("interrupt mode not entered");

    property p_hold;
        uart_int_reg && (|pend) |=> uart_int_reg;
    endproperty
    a_hold: assert property (p_hold) else $error("interrupt dropped while pending");

    property p_apb;
        setup |=> pready_reg ##1 !pready_reg;
    endproperty
    a_apb: assert property (p_apb) else $error("apb ready timing wrong");

    c_ls_int: cover property (pend[uip_pkg::SRC_LS] ##1 uart_int_reg);
    c_thr_wr: cover property (thr_reg ##1 thr_wr ##1 !thr_reg);
    c_ident_rd: cover property (ident_rd && prdata_reg[5:0] == uip_pkg::CODE_TX);
    c_evt_irq: cover property (evt_irq_reg);
endmodule : uip_top

// *** sim/uip_core_model.sv ***
// Purpose: behavioural uart core on the far side of the interrupt block
// Assumes: errored characters sit at the head of the receive fifo
// Notes:   receive trigger is two characters, transmit trigger is never reached
`timescale 1ns/1ps
module uip_core_model (
    input wire logic core_clk, // clock
    input wire logic rst_n, // async reset, active low
    input wire uip_pkg::uip_strobe_t strobe, // access pulses from the block
    input wire logic rx_push, // one character arrives
    input wire logic rx_push_err, // that character carries an error
    input wire logic ovr_pulse, // receiver overrun
    input wire logic tmo_pulse, // stale data time-out
    input wire logic tx_drain, // holding register moved on
    input wire logic fifo_mode, // uart core runs its fifos
    output uip_pkg::uip_src_t src // conditions to the block
);
    logic [3:0] rx_cnt_reg;
    logic [3:0] err_cnt_reg;
    logic tx_empty_reg;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_cnt_reg <= 4'h0;
            err_cnt_reg <= 4'h0;
        end else begin
            rx_cnt_reg <= rx_cnt_reg + 4'(rx_push) - 4'(strobe.rx_read && rx_cnt_reg != 4'h0);
            err_cnt_reg <= err_cnt_reg + 4'(rx_push && rx_push_err)
                - 4'(strobe.rx_read && err_cnt_reg != 4'h0);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_empty_reg <= 1'b1;
        end else if (strobe.tx_write) begin
            tx_empty_reg <= 1'b0;
        end else if (tx_drain) begin
            tx_empty_reg <= 1'b1;
        end
    end

    always_comb begin
        src = '0;
        src.err_in_fifo = err_cnt_reg != 4'h0;
        src.overrun_evt = ovr_pulse;
        src.rx_timeout_evt = tmo_pulse;
        src.rx_data_ready = rx_cnt_reg != 4'h0;
        src.fifo_enable = fifo_mode;
        src.rx_above_trig = rx_cnt_reg > 4'h1;
        src.tx_holding_empty = tx_empty_reg;
        src.line_status_in = {err_cnt_reg != 4'h0, 6'h00, rx_cnt_reg != 4'h0};
    end
endmodule : uip_core_model

// *** sim/tb_uart_interrupt_prioritizer.sv ***
// Purpose: self-checking bench of the uart interrupt prioritizer
// Assumes: apb answers with one access cycle, core model on the source side
// Notes:   settle waits cover the strobe, model and ident register delays
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb_uart_interrupt_prioritizer;
    logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, se, fifo_mode;
    logic uart_int, irq_mode, evt_irq, rx_push, rx_push_err, ovr_pulse, tmo_pulse, tx_drain;
    logic [4:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    uip_pkg::uip_src_t src;
    uip_pkg::uip_strobe_t strobe;
    int fails, comparisons, cyc;

    uip_top dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src(src), .strobe(strobe), .uart_int(uart_int),
        .irq_mode(irq_mode), .evt_irq(evt_irq));
    uip_core_model core (.core_clk(core_clk), .rst_n(rst_n), .strobe(strobe),
        .rx_push(rx_push), .rx_push_err(rx_push_err), .ovr_pulse(ovr_pulse),
        .tmo_pulse(tmo_pulse), .tx_drain(tx_drain), .fifo_mode(fifo_mode), .src(src));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // --------------------------------
    // bus and stimulus tasks
    // --------------------------------
    task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic expect_reg(input logic [4:0] a, input logic [31:0] e, input string n);
        apb(1'b0, a, 32'h0);
        `CHK(n, e, rd)
    endtask : expect_reg

    // k: b0 push, b1 overrun, b2 time-out, b3 drain, b4 errored push
    task automatic kick(input logic [4:0] k);
        @(posedge core_clk);
        rx_push <= k[0];
        ovr_pulse <= k[1];
        tmo_pulse <= k[2];
        tx_drain <= k[3];
        rx_push_err <= k[4];
        @(posedge core_clk);
        rx_push <= 1'b0;
        ovr_pulse <= 1'b0;
        tmo_pulse <= 1'b0;
        tx_drain <= 1'b0;
    endtask : kick

    task automatic settle();
        repeat (5) @(posedge core_clk);
    endtask : settle

    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic t_reset();
        expect_reg(uip_pkg::OFF_IDENT, 32'h01, "ident");
        expect_reg(uip_pkg::OFF_ENABLE, 32'h00, "enable");
        `CHK("uart_int", 1'b0, uart_int)
    endtask : t_reset

    task automatic t_rx_data();
        kick(5'h01);
        settle();
        `CHK("uart_int", 1'b0, uart_int)
        apb(1'b1, uip_pkg::OFF_ENABLE, 32'h01);
        settle();
        `CHK("uart_int", 1'b1, uart_int)
        `CHK("irq_mode", 1'b1, irq_mode)
        expect_reg(uip_pkg::OFF_IDENT, 32'h04, "ident");
        apb(1'b1, uip_pkg::OFF_ENABLE, 32'h00);
        settle();
        `CHK("uart_int", 1'b0, uart_int)
        `CHK("irq_mode", 1'b0, irq_mode)
        apb(1'b1, uip_pkg::OFF_ENABLE, 32'h01);
        apb(1'b0, uip_pkg::OFF_RXHOLD, 32'h0);
        settle();
        `CHK("uart_int", 1'b0, uart_int)
        expect_reg(uip_pkg::OFF_IDENT, 32'h01, "ident");
    endtask : t_rx_data

    task automatic t_line_err();
        apb(1'b1, uip_pkg::OFF_ENABLE, 32'h05);
        kick(5'h11);
        kick(5'h01);
        settle();
        expect_reg(uip_pkg::OFF_IDENT, 32'h06, "ident");
        expect_reg(uip_pkg::OFF_LSTAT, 32'h81, "line_status");
        apb(1'b0, uip_pkg::OFF_RXHOLD, 32'h0);
        settle();
        expect_reg(uip_pkg::OFF_IDENT, 32'h04, "ident");
        apb(1'b0, uip_pkg::OFF_RXHOLD, 32'h0);
        settle();
        expect_reg(uip_pkg::OFF_IDENT, 32'h01, "ident");
    endtask : t_line_err

    task automatic t_timeout();
        apb(1'b1, uip_pkg::OFF_ENABLE, 32'h01);
        kick(5'h05);
        settle();
        expect_reg(uip_pkg::OFF_IDENT, 32'h0c, "ident");
        apb(1'b0, uip_pkg::OFF_RXHOLD, 32'h0);
        settle();
        expect_reg(uip_pkg::OFF_IDENT, 32'h01, "ident");
    endtask : t_timeout

    // fifo mode: one character is data ready but below the two-character trigger
    task automatic t_fifo();
        fifo_mode <= 1'b1;
        apb(1'b1, uip_pkg::OFF_ENABLE, 32'h01);
        kick(5'h01);
        settle();
        `CHK("uart_int", 1'b0, uart_int)
        kick(5'h01);
        settle();
        expect_reg(uip_pkg::OFF_IDENT, 32'h04, "ident");
        apb(1'b0, uip_pkg::OFF_RXHOLD, 32'h0);
        settle();
        `CHK("uart_int", 1'b0, uart_int)
        apb(1'b0, uip_pkg::OFF_RXHOLD, 32'h0);
        settle();
        fifo_mode <= 1'b0;
    endtask : t_fifo

    task automatic t_overrun();
        apb(1'b1, uip_pkg::OFF_EVT_MASK, 32'h01);
        apb(1'b1, uip_pkg::OFF_ENABLE, 32'h04);
        // earlier scenarios left sticky bits behind; start from a clean status
        apb(1'b1, uip_pkg::OFF_EVT_STAT, 32'h3f);
        settle();
        `CHK("evt_irq", 1'b0, evt_irq)
        kick(5'h02);
        settle();
        expect_reg(uip_pkg::OFF_IDENT, 32'h06, "ident");
        `CHK("evt_irq", 1'b1, evt_irq)
        expect_reg(uip_pkg::OFF_EVT_STAT, 32'h01, "evt_stat");
        apb(1'b1, uip_pkg::OFF_EVT_STAT, 32'h01);
        settle();
        `CHK("evt_irq", 1'b0, evt_irq)
        expect_reg(uip_pkg::OFF_LSTAT, 32'h02, "line_status");
        settle();
        expect_reg(uip_pkg::OFF_IDENT, 32'h01, "ident");
        expect_reg(5'h1c, 32'h0, "unmapped_data");
        `CHK("pslverr", 1'b1, se)
    endtask : t_overrun

    task automatic t_tx();
        apb(1'b1, uip_pkg::OFF_ENABLE, 32'h02);
        apb(1'b1, uip_pkg::OFF_TXHOLD, 32'h5a);
        settle();
        `CHK("tx_data", 8'h5a, strobe.tx_data)
        kick(5'h08);
        settle();
        `CHK("uart_int", 1'b1, uart_int)
        expect_reg(uip_pkg::OFF_IDENT, 32'h02, "ident");
        expect_reg(uip_pkg::OFF_IDENT, 32'h01, "ident");
        apb(1'b1, uip_pkg::OFF_TXHOLD, 32'ha5);
        kick(5'h08);
        settle();
        `CHK("uart_int", 1'b1, uart_int)
        apb(1'b1, uip_pkg::OFF_TXHOLD, 32'h3c);
        settle();
        `CHK("uart_int", 1'b0, uart_int)
    endtask : t_tx

    task automatic close_out();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            close_out();
        end
    end

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 5'h00;
        pwdata = 32'h0;
        rx_push = 1'b0;
        rx_push_err = 1'b0;
        ovr_pulse = 1'b0;
        tmo_pulse = 1'b0;
        tx_drain = 1'b0;
        fifo_mode = 1'b0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_rx_data();
        t_line_err();
        t_timeout();
        t_fifo();
        t_overrun();
        t_tx();
        close_out();
    end
endmodule : tb_uart_interrupt_prioritizer
